// ### shared/bdsf_pkg.sv
// Purpose: constants and types for the drive supervisor
// Assumes: 20 MHz system clock
// Notes:   times kept in their own units, cycle counts derived
package bdsf_pkg;

  localparam int CLK_HZ        = 20_000_000;
  localparam int TB_DIV        = 2;
  localparam int TB_HZ         = CLK_HZ / TB_DIV;
  localparam int FILT_DIV      = 64;
  localparam int PWM_HZ        = 20_000;
  localparam int PWM_TICKS     = TB_HZ / PWM_HZ;
  localparam int DEAD_NS       = 1000;
  localparam int DEAD_TICKS    = (DEAD_NS * (TB_HZ / 1_000_000) + 999) / 1000;
  localparam int LOOP_HZ       = 500;
  localparam int LOOP_CYCLES   = CLK_HZ / LOOP_HZ;
  localparam int RAMP_MS       = 250;
  localparam int RAMP_STEPS    = RAMP_MS * LOOP_HZ / 1000;
  localparam int SPEED_MAX_RPM = 1200;
  localparam int RAMP_INC      = (SPEED_MAX_RPM + RAMP_STEPS - 1) / RAMP_STEPS;
  localparam int BTN_STEP_RPM  = 50;
  localparam int PC_PER_REV    = 2000;
  localparam int POLE_PAIRS    = 2;
  localparam int RPM_PER_CNT   = 60 * LOOP_HZ / PC_PER_REV;
  localparam int ALIGN_DUTY    = PWM_TICKS / 4;
  localparam int GAIN_SHIFT    = 15;

  localparam logic signed [23:0] P_GAIN = 24'sh004000;
  localparam logic signed [23:0] I_GAIN = 24'sh001000;

  localparam logic [3:0] CH_QD_A    = 4'h1;
  localparam logic [3:0] CH_QD_B    = 4'h2;
  localparam logic [3:0] CH_QD_IDX  = 4'h3;
  localparam logic [3:0] CH_OCP     = 4'h4;
  localparam logic [3:0] CH_SPEED   = 4'h5;
  localparam logic [3:0] CH_MASTER  = 4'h7;
  localparam logic [3:0] CH_PHASE_A = 4'h8;
  localparam logic [3:0] CH_PHASE_B = 4'ha;
  localparam logic [3:0] CH_PHASE_C = 4'hc;

  localparam logic [7:0] ADDR_SPEED  = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_POS    = 8'h08;
  localparam logic [7:0] ADDR_CHMAP  = 8'h0c;
  localparam logic [7:0] ADDR_CHMAP2 = 8'h10;

  localparam logic [1:0] INIT_CFG    = 2'h0;
  localparam logic [1:0] INIT_START  = 2'h1;
  localparam logic [1:0] INIT_DECIDE = 2'h2;

  typedef enum logic [2:0] {
    S_INIT    = 3'h0,
    S_STOP    = 3'h1,
    S_ENABLE  = 3'h2,
    S_RUN     = 3'h3,
    S_DISABLE = 3'h4,
    S_MFAULT  = 3'h5,
    S_GFAULT  = 3'h6
  } bdsf_state_t;

  typedef enum logic [2:0] {
    F_NONE        = 3'h0,
    F_OVERCURRENT = 3'h1,
    F_MICROCODE   = 3'h2,
    F_ILLEGAL     = 3'h3,
    F_MISC        = 3'h4
  } bdsf_fault_t;

endpackage : bdsf_pkg

// ### design/bdsf_encoder.sv
// Purpose: input filters and quadrature position counter
// Assumes: filt_en is a one-cycle pulse every FILT_DIV clocks
// Notes:   raw[0]=phase a, raw[1]=phase b, raw[2]=index
`timescale 1ns/1ns
`default_nettype none
module bdsf_encoder
  import bdsf_pkg::*;
#(
  parameter int PC_REV = PC_PER_REV
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        filt_en,
  input  wire logic [2:0]  raw,
  output logic      [10:0] position,
  output logic             step_fwd,
  output logic             step_rev
);

  logic [2:0] filt;
  logic [2:0] filt_q;
  logic       a_chg;
  logic       b_chg;

  // three equal samples needed before the filtered level moves
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_flt
      logic [2:0] smp;
      logic       lvl;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          smp <= 3'h0;
          lvl <= 1'b0;
        end else if (filt_en) begin
          smp <= {smp[1:0], raw[g]};
          if (smp == 3'h7) begin
            lvl <= 1'b1;
          end else if (smp == 3'h0) begin
            lvl <= 1'b0;
          end
        end
      end
      assign filt[g] = lvl;
    end
  endgenerate

  assign a_chg = filt[0] ^ filt_q[0];
  assign b_chg = filt[1] ^ filt_q[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_q   <= 3'h0;
      position <= 11'h000;
      step_fwd <= 1'b0;
      step_rev <= 1'b0;
    end else begin
      filt_q   <= filt;
      step_fwd <= 1'b0;
      step_rev <= 1'b0;
      if (filt[2] && !filt_q[2]) begin
        position <= 11'h000;
      end else if (a_chg ^ b_chg) begin
        // both edges at once is a lost step and is ignored
        if (filt[0] ^ filt_q[1]) begin
          step_fwd <= 1'b1;
          position <= (position == 11'(PC_REV - 1)) ? 11'h000 : position + 11'h001;
        end else begin
          step_rev <= 1'b1;
          position <= (position == 11'h000) ? 11'(PC_REV - 1) : position - 11'h001;
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_filter_gate: assert property ($changed(filt[0]) |-> $past(filt_en))
    else $error("filtered level moved without a filter tick");

  a_pos_wrap: assert property (step_fwd && $past(position) == 11'(PC_REV - 1) && !$past(filt[2])
                               |-> position == 11'h000)
    else $error("position did not wrap at one revolution");

endmodule : bdsf_encoder
`default_nettype wire

// ### design/bdsf_top.sv
// Purpose: supervisory state machine of a brushless drive with encoder
// Assumes: all inputs but sw_on_raw synchronous to clk; register port as documented below
// Notes:   commutation, dead time, ramp and speed loop sit beside the sequencer
`timescale 1ns/1ns
`default_nettype none
module bdsf_top
  import bdsf_pkg::*;
#(
  parameter int LOOP_CYC = LOOP_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        sw_on_raw,
  input  wire logic        btn_up,
  input  wire logic        btn_down,
  input  wire logic        ocp_in,
  input  wire logic        exc_microcode,
  input  wire logic        exc_illegal,
  input  wire logic        exc_misc,
  input  wire logic        stage_ready,
  input  wire logic [2:0]  enc_raw,
  output logic      [2:0]  gate_hi,
  output logic      [2:0]  gate_lo,
  output logic             pwm_enable,
  output logic             fault_led,
  output logic             ocp_armed,
  output logic             cfg_applied,
  output logic             timebase_run
);

  localparam int LW = $clog2(LOOP_CYC);
  localparam logic signed [47:0] INTEG_MAX = 48'(PWM_TICKS) <<< GAIN_SHIFT;

  bdsf_state_t state;
  bdsf_fault_t fault_code;
  logic [1:0]  init_step;
  logic        sw_meta;
  logic        sw_on;
  logic        ocp_q;
  logic        ocp_rise;
  logic        any_exc;
  logic        btn_up_q;
  logic        btn_down_q;
  logic [5:0]  fdiv;
  logic        filt_en;
  logic        tb_en;
  logic [LW-1:0] ldiv;
  logic        loop_en;
  logic [10:0] position;
  logic        step_fwd;
  logic        step_rev;
  logic signed [11:0] cnt_acc;
  logic signed [16:0] meas_rpm;
  logic [15:0] target_rpm;
  logic [15:0] speed_cmd;
  logic signed [16:0] err;
  logic signed [47:0] integ;
  logic signed [47:0] next_integ;
  logic signed [47:0] pi_sum;
  logic [9:0]  duty;
  logic [9:0]  pwm_cnt;
  logic        pwm_on;
  logic [2:0]  sector;

  function automatic bdsf_fault_t exc_code(input logic mc, input logic il);
    if (mc) begin
      return F_MICROCODE;
    end else if (il) begin
      return F_ILLEGAL;
    end
    return F_MISC;
  endfunction : exc_code

  // six electrical sectors per pole pair across the count range
  function automatic logic [2:0] sector_of(input logic [10:0] pos);
    int s;
    s = (int'(pos) * POLE_PAIRS * 6) / PC_PER_REV;
    return 3'(s % 6);
  endfunction : sector_of

  ////////////////////////////////////////////////////////////////////////////
  // inputs and dividers

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_meta    <= 1'b0;
      sw_on      <= 1'b0;
      ocp_q      <= 1'b0;
      btn_up_q   <= 1'b0;
      btn_down_q <= 1'b0;
    end else begin
      sw_meta    <= sw_on_raw;
      sw_on      <= sw_meta;
      ocp_q      <= ocp_in;
      btn_up_q   <= btn_up;
      btn_down_q <= btn_down;
    end
  end

  assign ocp_rise = ocp_in && !ocp_q;
  assign any_exc  = exc_microcode || exc_illegal || exc_misc;

  // timebase and loop dividers only run while the timebase is started; the filter divider always runs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fdiv    <= 6'h00;
      filt_en <= 1'b0;
      tb_en   <= 1'b0;
      ldiv    <= '0;
      loop_en <= 1'b0;
    end else begin
      fdiv    <= fdiv + 6'h01;
      filt_en <= (fdiv == 6'(FILT_DIV - 1));
      tb_en   <= timebase_run && !tb_en;
      loop_en <= 1'b0;
      if (!timebase_run || ldiv == LW'(LOOP_CYC - 1)) begin
        ldiv    <= '0;
        loop_en <= timebase_run;
      end else begin
        ldiv <= ldiv + 1'b1;
      end
    end
  end

  bdsf_encoder #(
    .PC_REV (PC_PER_REV)
  ) u_enc (
    .clk      (clk),
    .rst_n    (rst_n),
    .filt_en  (filt_en),
    .raw      (enc_raw),
    .position (position),
    .step_fwd (step_fwd),
    .step_rev (step_rev)
  );

  ////////////////////////////////////////////////////////////////////////////
  // supervisor

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state        <= S_INIT;
      init_step    <= INIT_CFG;
      pwm_enable   <= 1'b0;
      ocp_armed    <= 1'b0;
      fault_led    <= 1'b0;
      fault_code   <= F_NONE;
      cfg_applied  <= 1'b0;
      timebase_run <= 1'b0;
    end else if (any_exc) begin
      state        <= S_GFAULT;
      init_step    <= INIT_CFG;
      pwm_enable   <= 1'b0;
      ocp_armed    <= 1'b0;
      cfg_applied  <= 1'b0;
      timebase_run <= 1'b0;
      fault_code   <= exc_code(exc_microcode, exc_illegal);
    end else if (ocp_rise && ocp_armed && state != S_MFAULT && state != S_GFAULT) begin
      state      <= S_MFAULT;
      pwm_enable <= 1'b0;
      fault_led  <= 1'b1;
      fault_code <= F_OVERCURRENT;
    end else begin
      case (state)
        S_INIT: begin
          case (init_step)
            INIT_CFG: begin
              cfg_applied <= 1'b1;
              init_step   <= INIT_START;
            end
            INIT_START: begin
              timebase_run <= 1'b1;
              init_step    <= INIT_DECIDE;
            end
            default: begin
              init_step <= INIT_CFG;
              state     <= sw_on ? S_MFAULT : S_STOP;
            end
          endcase
        end
        S_STOP: begin
          if (sw_on) begin
            state <= S_ENABLE;
          end
        end
        S_ENABLE: begin
          pwm_enable <= 1'b1;
          if (stage_ready) begin
            ocp_armed <= 1'b1;
            state     <= S_RUN;
          end
        end
        S_RUN: begin
          if (!sw_on) begin
            state <= S_DISABLE;
          end
        end
        S_DISABLE: begin
          pwm_enable <= 1'b0;
          if (!stage_ready) begin
            state <= S_STOP;
          end
        end
        S_MFAULT: begin
          if (!sw_on) begin
            fault_led <= 1'b0;
            state     <= S_STOP;
          end
        end
        S_GFAULT: begin
          if (!sw_on) begin
            state <= S_INIT;
          end
        end
        default: state <= S_INIT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // required speed: host register, buttons, ramp

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      target_rpm <= 16'h0000;
    end else if (state == S_ENABLE || state == S_DISABLE || state == S_MFAULT || state == S_GFAULT) begin
      target_rpm <= 16'h0000;
    end else if (wr && addr == ADDR_SPEED) begin
      target_rpm <= (wdata[15:0] > 16'(SPEED_MAX_RPM)) ? 16'(SPEED_MAX_RPM) : wdata[15:0];
    end else if (btn_up && !btn_up_q) begin
      target_rpm <= (target_rpm + 16'(BTN_STEP_RPM) > 16'(SPEED_MAX_RPM)) ?
                    16'(SPEED_MAX_RPM) : target_rpm + 16'(BTN_STEP_RPM);
    end else if (btn_down && !btn_down_q) begin
      target_rpm <= (target_rpm < 16'(BTN_STEP_RPM)) ? 16'h0000 : target_rpm - 16'(BTN_STEP_RPM);
    end
  end

  // speed command follows the target at a bounded slope, once per loop tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      speed_cmd <= 16'h0000;
    end else if (state != S_RUN) begin
      speed_cmd <= 16'h0000;
    end else if (loop_en) begin
      if (target_rpm > speed_cmd + 16'(RAMP_INC)) begin
        speed_cmd <= speed_cmd + 16'(RAMP_INC);
      end else if (target_rpm + 16'(RAMP_INC) < speed_cmd) begin
        speed_cmd <= speed_cmd - 16'(RAMP_INC);
      end else begin
        speed_cmd <= target_rpm;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // speed measurement and pi loop

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_acc  <= 12'sh000;
      meas_rpm <= 17'sh00000;
    end else if (loop_en) begin
      cnt_acc  <= 12'sh000;
      // widen before the product so a fast shaft cannot overflow the count
      meas_rpm <= 17'(cnt_acc) * 17'sd15;
    end else if (step_fwd) begin
      cnt_acc <= cnt_acc + 12'sh001;
    end else if (step_rev) begin
      cnt_acc <= cnt_acc - 12'sh001;
    end
  end

  assign err        = $signed({1'b0, speed_cmd}) - meas_rpm;
  assign next_integ = integ + 48'(err) * 48'(I_GAIN);
  assign pi_sum     = (48'(err) * 48'(P_GAIN) + integ) >>> GAIN_SHIFT;

  // integrator clamped to the duty range so it cannot wind up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      integ <= 48'sh0;
      duty  <= 10'h000;
    end else if (state == S_ENABLE) begin
      integ <= 48'sh0;
      duty  <= 10'(ALIGN_DUTY);
    end else if (state != S_RUN) begin
      integ <= 48'sh0;
      duty  <= 10'h000;
    end else if (loop_en) begin
      if (next_integ < 48'sh0) begin
        integ <= 48'sh0;
      end else if (next_integ > INTEG_MAX) begin
        integ <= INTEG_MAX;
      end else begin
        integ <= next_integ;
      end
      if (pi_sum < 48'sh0) begin
        duty <= 10'h000;
      end else if (pi_sum > 48'(PWM_TICKS)) begin
        duty <= 10'(PWM_TICKS);
      end else begin
        duty <= pi_sum[9:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // commutated complementary pwm with dead time

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_cnt <= 10'h000;
    end else if (tb_en) begin
      pwm_cnt <= (pwm_cnt == 10'(PWM_TICKS - 1)) ? 10'h000 : pwm_cnt + 10'h001;
    end
  end

  assign pwm_on = pwm_cnt < duty;
  assign sector = (state == S_ENABLE) ? 3'h0 : sector_of(position);

  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_phase
      logic       hi;
      logic       lo;
      logic       want_hi;
      logic       want_lo;
      logic [4:0] dt;
      logic       drv_pos;
      logic       drv_neg;
      assign drv_pos = (32'(sector) / 2) == p;
      assign drv_neg = (((32'(sector) + 1) % 6) / 2) == ((p + 2) % 3);
      assign want_hi = pwm_enable && drv_pos && pwm_on;
      assign want_lo = pwm_enable && (drv_neg || (drv_pos && !pwm_on));
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          hi <= 1'b0;
          lo <= 1'b0;
          dt <= 5'h00;
        end else if (hi != want_hi || lo != want_lo) begin
          // a switch always passes through both-off for the dead time
          if (hi || lo) begin
            hi <= 1'b0;
            lo <= 1'b0;
            dt <= 5'h00;
          end else if (dt >= 5'(DEAD_TICKS)) begin
            hi <= want_hi;
            lo <= want_lo;
          end else if (tb_en) begin
            dt <= dt + 5'h01;
          end
        end else if (!hi && !lo && tb_en && dt < 5'(DEAD_TICKS)) begin
          dt <= dt + 5'h01;
        end
      end
      assign gate_hi[p] = hi;
      assign gate_lo[p] = lo;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // register read port

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h00000000;
    end else if (!rd) begin
      rdata <= 32'h00000000;
    end else begin
      case (addr)
        ADDR_SPEED:  rdata <= {16'h0000, target_rpm};
        ADDR_STATUS: rdata <= {21'h00000, timebase_run, cfg_applied, ocp_armed, pwm_enable,
                               fault_led, fault_code, state};
        ADDR_POS:    rdata <= {speed_cmd[15:0], 5'h00, position};
        ADDR_CHMAP:  rdata <= {CH_PHASE_B, CH_PHASE_A, CH_MASTER, CH_SPEED,
                               CH_OCP, CH_QD_IDX, CH_QD_B, CH_QD_A};
        ADDR_CHMAP2: rdata <= {28'h0000000, CH_PHASE_C};
        default:     rdata <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic rst_seen;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_seen <= 1'b0;
    end else begin
      rst_seen <= 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seq_cfg_only;
    cfg_applied && !timebase_run;
  endsequence
  sequence seq_started;
    cfg_applied && timebase_run;
  endsequence

  a_reset_init: assert property (!rst_seen |-> state == S_INIT)
    else $error("first state after reset is not init");
  a_init_exit: assert property (state == S_INIT && init_step == INIT_DECIDE && !any_exc
                                |=> state == ($past(sw_on) ? S_MFAULT : S_STOP))
    else $error("wrong exit from init");
  a_init_order: assert property ((state == S_INIT && init_step == INIT_CFG && !any_exc ##1 !any_exc)
                                 |-> seq_cfg_only ##1 seq_started)
    else $error("timebase started before settings applied");
  a_stop_gates: assert property (state == S_STOP |-> !pwm_enable ##1 (gate_hi | gate_lo) == 3'h0)
    else $error("gates active in stop");
  a_enable_hold: assert property (state == S_ENABLE && !stage_ready && !any_exc && !(ocp_rise && ocp_armed)
                                  |=> state == S_ENABLE && pwm_enable)
    else $error("enable left without success");
  a_enable_run: assert property (state == S_ENABLE && stage_ready && !any_exc && !(ocp_rise && ocp_armed)
                                 |=> state == S_RUN && ocp_armed && pwm_enable)
    else $error("enable success did not arm and run");
  a_disable_hold: assert property (state == S_DISABLE && stage_ready && !any_exc && !(ocp_rise && ocp_armed)
                                   |=> state == S_DISABLE && !pwm_enable)
    else $error("disable left without success");
  a_ocp_fault: assert property (ocp_rise && ocp_armed && !any_exc && state != S_MFAULT && state != S_GFAULT
                                |=> state == S_MFAULT && !pwm_enable && fault_led
                                    && fault_code == F_OVERCURRENT ##1 target_rpm == 16'h0000)
    else $error("over-current not handled");
  a_gfault: assert property (any_exc |=> state == S_GFAULT && !timebase_run && !pwm_enable)
    else $error("exception did not force global fault");
  a_gate_pair: assert property ((gate_hi & gate_lo) == 3'h0)
    else $error("high and low gate of one phase on together");
  a_mfault_exit: assert property (state == S_MFAULT && !sw_on && !any_exc
                                  |=> state == S_STOP && !fault_led)
    else $error("motor fault not cleared by switch off");
  a_ramp_step: assert property (state == S_RUN && $past(state) == S_RUN && $changed(speed_cmd)
                                |-> (speed_cmd > $past(speed_cmd) ? speed_cmd - $past(speed_cmd)
                                     : $past(speed_cmd) - speed_cmd) <= 16'(RAMP_INC))
    else $error("speed command stepped faster than the ramp");

endmodule : bdsf_top
`default_nettype wire

// ### sim/bdsf_stage_model.sv
// Purpose: power stage and encoder stand-in
// Assumes: stage follows pwm_enable after a lag
// Notes:   slow lengthens the lag so enable/disable dwell
`timescale 1ns/1ns
`default_nettype none
module bdsf_stage_model (
  input  wire logic       clk,
  input  wire logic       pwm_enable,
  input  wire logic       slow,
  output logic            stage_ready = 1'b0,
  output logic      [2:0] enc_raw = 3'h0
);
  logic [3:0]  lag = 4'h0;
  logic [11:0] t = 12'h0;
  always_ff @(posedge clk) begin
    lag <= (stage_ready == pwm_enable) ? 4'h0 : lag + 4'h1;
    if (lag == (slow ? 4'h9 : 4'h1)) stage_ready <= pwm_enable;
    t <= t + 12'h1;
    // slow quadrature steps, well past the filter window
    if (t == 12'hfff) enc_raw[1:0] <= {enc_raw[0], ~enc_raw[1]};
  end
endmodule : bdsf_stage_model
`default_nettype wire

// ### sim/bdsf_top_test.sv
// Purpose: self-checking bench for the drive supervisor
// Assumes: short speed-loop period
// Notes:   state seen through the status register
`timescale 1ns/1ns
`default_nettype none
module bdsf_top_test import bdsf_pkg::*;;
  logic        clk, rst_n, wr, rd, sw, up, dn, ocp, slow;
  logic        pwm_enable, stage_ready, led, armed, cfgd, tbr;
  logic [2:0]  exc, enc, ghi, glo;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, d, p, v, seed;
  int          err_total, n_checks;
  bdsf_top #(.LOOP_CYC(400)) dut (
    .clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .sw_on_raw(sw), .btn_up(up),
    .btn_down(dn), .ocp_in(ocp), .exc_microcode(exc[0]), .exc_illegal(exc[1]),
    .exc_misc(exc[2]), .stage_ready, .enc_raw(enc), .gate_hi(ghi), .gate_lo(glo),
    .pwm_enable, .fault_led(led), .ocp_armed(armed), .cfg_applied(cfgd), .timebase_run(tbr)
  );
  bdsf_stage_model stage (.clk, .pwm_enable, .slow, .stage_ready, .enc_raw(enc));
  ////////////////////////////////////////
  function automatic logic [31:0] clamp(input logic [31:0] x);
    return (x > SPEED_MAX_RPM) ? SPEED_MAX_RPM : x;
  endfunction : clamp
  // one speed-loop tick of the ramp toward target t
  function automatic logic [31:0] ramp_to(input logic [31:0] c, input logic [31:0] t);
    if (t > c + RAMP_INC) return c + RAMP_INC;
    if (t + RAMP_INC < c) return c - RAMP_INC;
    return t;
  endfunction : ramp_to
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rdreg(input logic [7:0] a);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask : rdreg
  task automatic wrreg(input logic [7:0] a, input logic [31:0] x);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= x;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrreg
  // bounded poll; a miss lands as a mismatch
  task automatic wst(input bdsf_state_t s);
    for (int i = 0; i < 60; i++) begin
      rdreg(ADDR_STATUS);
      if (d[2:0] === s) break;
    end
    chk("state", {29'h0, s}, {29'h0, d[2:0]});
  endtask : wst
  task automatic tally_and_finish;
    if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    seed = 32'hb4bbaea5;
    {rst_n, wr, rd, sw, up, dn, ocp, slow} = 8'h01;
    {addr, wdata, exc} = 43'h0;
    err_total = 0;
    n_checks = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rdreg(ADDR_STATUS);
    chk("boot", 32'h8, {27'h0, d[10:9], d[2:0]});
    wst(S_STOP);
    chk("started", 32'h3, {30'h0, d[10:9]});
    rdreg(ADDR_CHMAP);
    chk("chmap", 32'ha8754321, d);
    rdreg(ADDR_CHMAP2);
    chk("chmap2", 32'hc, d);
    rdreg(8'h14);
    chk("unmapped", 32'h0, d);
    rdreg(ADDR_POS);
    p = d;
    repeat (9000) @(posedge clk);
    rdreg(ADDR_POS);
    chk("hand turn", 32'h1, {31'h0, p[10:0] !== d[10:0]});
    // over-current edge before the first enable must be ignored
    ocp <= 1'b1;
    repeat (3) @(posedge clk);
    ocp <= 1'b0;
    wst(S_STOP);
    chk("unarmed", 32'h0, {29'h0, d[5:3]});
    wrreg(ADDR_SPEED, 32'h64);
    sw <= 1'b1;
    wst(S_ENABLE);
    rdreg(ADDR_SPEED);
    chk("en speed", 32'h0, d);
    wst(S_RUN);
    chk("armed", 32'h3, {30'h0, d[8:7]});
    chk("pins", 32'he, {28'h0, tbr, cfgd, armed, led});
    v = $random(seed) & 32'h7ff;
    wrreg(ADDR_SPEED, v);
    up <= 1'b1;
    @(posedge clk);
    up <= 1'b0;
    repeat (4) @(posedge clk);
    rdreg(ADDR_SPEED);
    v = clamp(clamp(v) + 32'h32);
    chk("speed", v, d);
    dn <= 1'b1;
    @(posedge clk);
    dn <= 1'b0;
    repeat (4) @(posedge clk);
    rdreg(ADDR_SPEED);
    v = v - 32'h32;
    chk("speed dn", v, d);
    // samples 400 clocks apart hold exactly one loop tick
    rdreg(ADDR_POS);
    p = d;
    repeat (397) @(posedge clk);
    rdreg(ADDR_POS);
    chk("ramp", ramp_to({16'h0, p[31:16]}, v), {16'h0, d[31:16]});
    chk("gate pair", 32'h0, {29'h0, ghi & glo});
    chk("low side", 32'h1, {31'h0, |glo});
    sw <= 1'b0;
    wst(S_DISABLE);
    wst(S_STOP);
    chk("pwm off", 32'h0, {31'h0, pwm_enable});
    chk("stop gates", 32'h0, {26'h0, ghi, glo});
    rdreg(ADDR_SPEED);
    chk("dis speed", 32'h0, d);
    slow <= 1'b0;
    sw <= 1'b1;
    wst(S_RUN);
    ocp <= 1'b1;
    wst(S_MFAULT);
    chk("ocp", 32'h9, {27'h0, d[7:3]});
    chk("led pin", 32'h1, {31'h0, led});
    ocp <= 1'b0;
    sw <= 1'b0;
    wst(S_STOP);
    chk("led off", 32'h0, {31'h0, d[6]});
    for (int i = 0; i < 3; i++) begin
      sw <= 1'b1;
      wst(S_RUN);
      exc <= 3'h1 << i;
      wst(S_GFAULT);
      chk("code", 32'h2 + 32'(i), {29'h0, d[5:3]});
      chk("gf pins", 32'h0, {29'h0, tbr, cfgd, armed});
      exc <= 3'h0;
      sw <= 1'b0;
      wst(S_STOP);
    end
    // reset from stop with the switch on: init must exit to motor fault
    sw    <= 1'b1;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wst(S_MFAULT);
    sw <= 1'b0;
    wst(S_STOP);
    tally_and_finish();
  end
endmodule : bdsf_top_test
`default_nettype wire
